// File: logic/ddrb_pkg.sv
// shared constants, types and decoders of the ddr burst memory interface
package ddrb_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;   // ref_clk period, 200 MHz
  localparam int BEAT_TIME_PS = 62500;   // one data beat, half a link clock period
  localparam int BEAT_CYC_RAW = BEAT_TIME_PS / CLK_PERIOD_PS;
  localparam int BEAT_CYC = (BEAT_CYC_RAW < 1) ? 1 : BEAT_CYC_RAW;
  localparam int TICK_W = 8;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NUM_BANKS = 16;
  localparam int BANK_W = 4;
  localparam int ADDR_W = 20;
  localparam int ROW_W = 16;
  localparam int DQ_W = 36;
  localparam int GROUP_W = 9;            // data balls per read clock pair
  localparam int NUM_RCLK = 4;
  localparam int MASK_W = 2;
  localparam int FIFO_DEPTH = 32;
  localparam int BLEN_W = 4;

  // ----------------------------------------------------------------
  // burst length field of the mode set command
  // ----------------------------------------------------------------
  localparam int BLCODE_LSB = 0;
  localparam logic [1:0] BLCODE_2 = 2'h0;
  localparam logic [1:0] BLCODE_4 = 2'h1;
  localparam logic [1:0] BLCODE_8 = 2'h2;
  localparam logic [BLEN_W-1:0] BURST_LEN_RESET = 4'h2;
  localparam logic [ROW_W-1:0] ROW_RESET = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WRITE = 2'h1,
    ST_READ = 2'h2
  } ddrb_state_e;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_READ = 3'h1,
    CMD_WRITE = 3'h2,
    CMD_REFRESH = 3'h3,
    CMD_MODE = 3'h4
  } ddrb_cmd_e;

  // burst length in beats for a mode code, zero for an illegal code
  function automatic logic [BLEN_W-1:0] ddrb_burst_len(input logic [1:0] code);
    logic [BLEN_W-1:0] len;
    len = 4'h0;
    case (code)
      BLCODE_2: len = 4'h2;
      BLCODE_4: len = 4'h4;
      BLCODE_8: len = 4'h8;
      default: len = 4'h0;
    endcase
    return len;
  endfunction

  // command decode from the three control pins
  function automatic ddrb_cmd_e ddrb_decode(input logic csN, input logic weN, input logic refN);
    ddrb_cmd_e cmd;
    cmd = CMD_NOP;
    if (!csN) begin
      case ({weN, refN})
        2'h0: cmd = CMD_MODE;
        2'h1: cmd = CMD_WRITE;
        2'h2: cmd = CMD_REFRESH;
        default: cmd = CMD_READ;
      endcase
    end
    return cmd;
  endfunction

endpackage

// File: logic/ddrb_fifo.sv
// data fifo with a registered head word between write and read bursts
`timescale 1ns/10ps
module ddrb_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,              // clock
  input wire logic rst,                  // synchronous reset, high
  input wire logic [WIDTH-1:0] inData,   // word to store
  input wire logic inValid,              // inData offered
  output logic inReady,                  // room for a word
  output logic [WIDTH-1:0] outData,      // head word, from a register
  output logic outValid,                 // head word present
  input wire logic outReady              // head word taken
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_reg;
  logic [AW:0] wrPtr_next;
  logic [AW:0] rdPtr_reg;
  logic [AW:0] rdPtr_next;
  logic [WIDTH-1:0] head_reg;
  logic [WIDTH-1:0] head_next;
  logic headValid_reg;
  logic headValid_next;
  logic push;
  logic load;

  // pointer arithmetic, head refill when empty or taken
  always_comb begin
    inReady = (wrPtr_reg - rdPtr_reg) != (AW + 1)'(DEPTH);
    push = inValid && inReady;
    load = (wrPtr_reg != rdPtr_reg) && (!headValid_reg || outReady);
    wrPtr_next = wrPtr_reg + (AW + 1)'(push);
    rdPtr_next = rdPtr_reg + (AW + 1)'(load);
    head_next = load ? mem[rdPtr_reg[AW-1:0]] : head_reg;
    headValid_next = load || (headValid_reg && !outReady);
    outData = head_reg;
    outValid = headValid_reg;
  end

  // storage array, no reset on the data words
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wrPtr_reg[AW-1:0]] <= inData;
    end
  end

  // pointers and head register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      head_reg <= '0;
      headValid_reg <= 1'b0;
    end else begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      head_reg <= head_next;
      headValid_reg <= headValid_next;
    end
  end

endmodule

// File: logic/ddrb_mem_if.sv
// device side of a sixteen bank ddr burst memory command and data interface
// Behaviour
// [R1] each data ball moves two bits per clock cycle, one per phase
// [R2] commands, address and control are sampled only on command clock rising edges
// [R3] write data is captured on both edges of the write data strobe
// [R4] read data leaves aligned with the device's own read data clocks
// [R5] bursts are 2, 4 or 8 words, set by the mode set command
// [R6] sixteen banks, chosen by bank address for each access and refresh
// [R7] refresh names a bank; the row comes from a counter per bank
// [R8] four read clock pairs, each timing a group of nine data balls
// [R9] two pair users take pair 0 and pair 1 with their fixed groups
// [R10] controller runs the device with its delay locked loop enabled
// [R11] controller issues only documented commands and sequences; the bench also sends a mode set with the illegal burst code 3
// [R12] the whole address is taken in one command cycle
// [R13] controller counts beats and turns the bus only after the burst
`timescale 1ns/10ps
module ddrb_mem_if
  import ddrb_pkg::*;
(
  input wire logic ref_clk,                      // 200 MHz clock
  input wire logic rst,                          // synchronous reset, high
  input wire logic cmdClk,                       // command clock pair, true side
  input wire logic csN,                          // chip select, low
  input wire logic weN,                          // write enable, low
  input wire logic refN,                         // refresh, low
  input wire logic [BANK_W-1:0] bankAddr,        // bank address
  input wire logic [ADDR_W-1:0] addr,            // full address
  input wire logic writeDataStrobe,              // write strobe pair, true side
  input wire logic [DQ_W-1:0] dqIn,              // data balls, input side
  input wire logic [MASK_W-1:0] writeByteMask,   // write mask, high masks
  output logic [DQ_W-1:0] dqOut,                 // data balls, output side
  output logic dqOeN,                            // data drive enable, low drives
  output logic [NUM_RCLK-1:0] readDataClock,     // read data clocks
  output logic readValidFlag,                    // read beat on the balls
  output logic [BLEN_W-1:0] burstLen,            // programmed burst length
  output logic [BANK_W-1:0] accessBank,          // bank of last access
  output logic [ADDR_W-1:0] accessAddr,          // address of last access
  output logic [BANK_W-1:0] refreshBank,         // bank of last refresh
  output logic [ROW_W-1:0] refreshRow,           // row of last refresh
  output logic writeDropped                      // write beat lost, fifo full
);

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  localparam int SYNC_W = 5 + BANK_W + ADDR_W + DQ_W + MASK_W;
  localparam int LANE_W = DQ_W / MASK_W;

  logic [SYNC_W-1:0] pinWord;
  logic [SYNC_W-1:0] syncA_reg;
  logic [SYNC_W-1:0] syncB_reg;
  logic sClk;
  logic sCsN;
  logic sWeN;
  logic sRefN;
  logic sDk;
  logic [BANK_W-1:0] sBank;
  logic [ADDR_W-1:0] sAddr;
  logic [DQ_W-1:0] sDq;
  logic [MASK_W-1:0] sMask;

  assign pinWord = {cmdClk, csN, weN, refN, writeDataStrobe, bankAddr, addr, dqIn,
                    writeByteMask};

  // two flops on every pin before any logic
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
    end else begin
      syncA_reg <= pinWord;
      syncB_reg <= syncA_reg;
    end
  end

  assign {sClk, sCsN, sWeN, sRefN, sDk, sBank, sAddr, sDq, sMask} = syncB_reg;

  // ----------------------------------------------------------------
  // state and data path
  // ----------------------------------------------------------------
  ddrb_state_e state_reg;
  ddrb_state_e state_next;
  ddrb_cmd_e cmd;
  logic clkPrev_reg;
  logic clkPrev_next;
  logic dkPrev_reg;
  logic dkPrev_next;
  logic cmdRise;
  logic dkEdge;
  logic beatTick;
  logic [TICK_W-1:0] tick_reg;
  logic [TICK_W-1:0] tick_next;
  logic [BLEN_W-1:0] burstLen_reg;
  logic [BLEN_W-1:0] burstLen_next;
  logic [BLEN_W-1:0] beatsLeft_reg;
  logic [BLEN_W-1:0] beatsLeft_next;
  logic [DQ_W-1:0] dqOut_reg;
  logic [DQ_W-1:0] dqOut_next;
  logic dqOeN_reg;
  logic dqOeN_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [NUM_RCLK-1:0] rclk_reg;
  logic [NUM_RCLK-1:0] rclk_next;
  logic [BANK_W-1:0] accessBank_reg;
  logic [BANK_W-1:0] accessBank_next;
  logic [ADDR_W-1:0] accessAddr_reg;
  logic [ADDR_W-1:0] accessAddr_next;
  logic [BANK_W-1:0] refreshBank_reg;
  logic [BANK_W-1:0] refreshBank_next;
  logic [ROW_W-1:0] refreshRow_reg;
  logic [ROW_W-1:0] refreshRow_next;
  logic [ROW_W-1:0] rowCnt_reg [NUM_BANKS];
  logic [ROW_W-1:0] rowCnt_next [NUM_BANKS];
  logic dropped_reg;
  logic dropped_next;
  logic [DQ_W-1:0] maskedDq;
  logic fifoInValid;
  logic fifoInReady;
  logic [DQ_W-1:0] fifoOutData;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [BLEN_W-1:0] codeLen;

  assign cmdRise = sClk && !clkPrev_reg;
  assign dkEdge = sDk ^ dkPrev_reg;
  assign beatTick = tick_reg == TICK_W'(BEAT_CYC - 1);
  assign cmd = ddrb_decode(sCsN, sWeN, sRefN);
  assign codeLen = ddrb_burst_len(sAddr[BLCODE_LSB +: 2]);

  // masked lanes are stored as zero
  for (genvar g = 0; g < MASK_W; g++) begin : g_mask
    assign maskedDq[g * LANE_W +: LANE_W] = sMask[g] ? '0 : sDq[g * LANE_W +: LANE_W];
  end

  ddrb_fifo #(
    .WIDTH(DQ_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .inData(maskedDq),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .outData(fifoOutData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady)
  );

  // command decode, burst sequencing and refresh counters
  always_comb begin
    state_next = state_reg;
    clkPrev_next = sClk;
    dkPrev_next = sDk;
    tick_next = beatTick ? '0 : tick_reg + 1'b1;
    burstLen_next = burstLen_reg;
    beatsLeft_next = beatsLeft_reg;
    dqOut_next = dqOut_reg;
    dqOeN_next = dqOeN_reg;
    rvalid_next = rvalid_reg;
    rclk_next = rclk_reg;
    accessBank_next = accessBank_reg;
    accessAddr_next = accessAddr_reg;
    refreshBank_next = refreshBank_reg;
    refreshRow_next = refreshRow_reg;
    rowCnt_next = rowCnt_reg;
    dropped_next = 1'b0;
    fifoInValid = 1'b0;
    fifoOutReady = 1'b0;
    // [R1] [R8] all read clocks flip per beat
    if (beatTick) begin
      rclk_next = ~rclk_reg;
    end
    // [R2] sample only at command rise
    if (cmdRise) begin
      // [R7] bank named, row internal
      if (cmd == CMD_REFRESH) begin
        refreshBank_next = sBank;
        refreshRow_next = rowCnt_reg[sBank];
        rowCnt_next[sBank] = rowCnt_reg[sBank] + 1'b1;
      end
      if (state_reg == ST_IDLE) begin
        case (cmd)
          // [R5] legal lengths only
          CMD_MODE: begin
            if (codeLen != '0) begin
              burstLen_next = codeLen;
            end
          end
          // [R12] full address in one edge
          CMD_WRITE: begin
            if (fifoInReady) begin
              state_next = ST_WRITE;
              beatsLeft_next = burstLen_reg;
              accessBank_next = sBank;
              accessAddr_next = sAddr;
            end
          end
          // [R6] bank chosen per access
          CMD_READ: begin
            state_next = ST_READ;
            beatsLeft_next = burstLen_reg;
            accessBank_next = sBank;
            accessAddr_next = sAddr;
          end
          default: begin
          end
        endcase
      end
    end
    case (state_reg)
      // [R3] capture on either strobe edge
      ST_WRITE: begin
        if (dkEdge) begin
          fifoInValid = 1'b1;
          dropped_next = !fifoInReady;
          beatsLeft_next = beatsLeft_reg - 1'b1;
          if (beatsLeft_reg == 4'h1) begin
            state_next = ST_IDLE;
          end
        end
      end
      // [R4] data changes with the read clock
      ST_READ: begin
        if (beatTick) begin
          if (beatsLeft_reg != '0) begin
            dqOut_next = fifoOutValid ? fifoOutData : '0;
            fifoOutReady = 1'b1;
            rvalid_next = 1'b1;
            dqOeN_next = 1'b0;
            beatsLeft_next = beatsLeft_reg - 1'b1;
          end else begin
            rvalid_next = 1'b0;
            dqOeN_next = 1'b1;
            state_next = ST_IDLE;
          end
        end
      end
      default: begin
      end
    endcase
  end

  // state registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      clkPrev_reg <= 1'b0;
      dkPrev_reg <= 1'b0;
      tick_reg <= '0;
      burstLen_reg <= BURST_LEN_RESET;
      beatsLeft_reg <= '0;
      dqOut_reg <= '0;
      dqOeN_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rclk_reg <= '0;
      accessBank_reg <= '0;
      accessAddr_reg <= '0;
      refreshBank_reg <= '0;
      refreshRow_reg <= ROW_RESET;
      rowCnt_reg <= '{default: ROW_RESET};
      dropped_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      clkPrev_reg <= clkPrev_next;
      dkPrev_reg <= dkPrev_next;
      tick_reg <= tick_next;
      burstLen_reg <= burstLen_next;
      beatsLeft_reg <= beatsLeft_next;
      dqOut_reg <= dqOut_next;
      dqOeN_reg <= dqOeN_next;
      rvalid_reg <= rvalid_next;
      rclk_reg <= rclk_next;
      accessBank_reg <= accessBank_next;
      accessAddr_reg <= accessAddr_next;
      refreshBank_reg <= refreshBank_next;
      refreshRow_reg <= refreshRow_next;
      rowCnt_reg <= rowCnt_next;
      dropped_reg <= dropped_next;
    end
  end

  // outputs straight from flops
  assign dqOut = dqOut_reg;
  assign dqOeN = dqOeN_reg;
  assign readDataClock = rclk_reg;
  assign readValidFlag = rvalid_reg;
  assign burstLen = burstLen_reg;
  assign accessBank = accessBank_reg;
  assign accessAddr = accessAddr_reg;
  assign refreshBank = refreshBank_reg;
  assign refreshRow = refreshRow_reg;
  assign writeDropped = dropped_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [BLEN_W-1:0] rdBeats_reg;

  // read beats counted per burst
  always_ff @(posedge ref_clk) begin
    if (rst || state_reg == ST_IDLE) begin
      rdBeats_reg <= '0;
    end else if (fifoOutReady) begin
      rdBeats_reg <= rdBeats_reg + 1'b1;
    end
  end

  a_two_beats_clock: assert property (@(posedge ref_clk) disable iff (rst) // [R1]
    beatTick |=> readDataClock[0] != $past(readDataClock[0]) ##1
      readDataClock[0] == $past(readDataClock[0]))
    else $error("read clock did not flip once per beat");

  a_cmd_rise_only: assert property (@(posedge ref_clk) disable iff (rst) // [R2]
    (state_reg == ST_IDLE && state_next != ST_IDLE) |-> cmdRise)
    else $error("burst started away from a command clock rise");

  a_write_both_edges: assert property (@(posedge ref_clk) disable iff (rst) // [R3]
    (fifoInValid && fifoInReady) |=> u_fifo.wrPtr_reg != $past(u_fifo.wrPtr_reg))
    else $error("write strobe edge did not capture data");

  a_read_clock_align: assert property (@(posedge ref_clk) disable iff (rst) // [R4]
    $changed(dqOut) |-> $changed(readDataClock))
    else $error("read data moved without a read clock edge");

  a_burst_len_legal: assert property (@(posedge ref_clk) disable iff (rst) // [R5]
    burstLen == 4'h2 || burstLen == 4'h4 || burstLen == 4'h8)
    else $error("illegal burst length programmed");

  a_read_beat_count: assert property (@(posedge ref_clk) disable iff (rst) // [R5]
    (state_reg == ST_READ && state_next == ST_IDLE) |-> rdBeats_reg == burstLen_reg)
    else $error("read burst beat count differs from burst length");

  a_refresh_bank_row: assert property (@(posedge ref_clk) disable iff (rst) // [R7]
    (cmdRise && cmd == CMD_REFRESH) |=>
      refreshBank == $past(sBank) && refreshRow == $past(rowCnt_reg[sBank]))
    else $error("refresh bank or row wrong");

  a_read_clock_group: assert property (@(posedge ref_clk) disable iff (rst) // [R8]
    (&readDataClock) || !(|readDataClock))
    else $error("read clock pairs out of step");

  a_single_cycle_addr: assert property (@(posedge ref_clk) disable iff (rst) // [R12]
    (state_reg == ST_IDLE && state_next != ST_IDLE) |=>
      accessAddr == $past(sAddr) && accessBank == $past(sBank))
    else $error("access address not taken in one command cycle");

endmodule

// File: verif/ddrb_ctrl_model.sv
// controller model: drives commands and write beats, captures read beats
`timescale 1ns/10ps
module ddrb_ctrl_model
  import ddrb_pkg::*;
(
  output logic cmdClk,                            // command clock
  output logic csN,                               // chip select, low
  output logic weN,                               // write enable, low
  output logic refN,                              // refresh, low
  output logic [BANK_W-1:0] bankAddr,             // bank address
  output logic [ADDR_W-1:0] addr,                 // full address
  output logic writeDataStrobe,                   // write strobe
  output logic [DQ_W-1:0] dqIn,                   // write data
  output logic [MASK_W-1:0] writeByteMask,        // lane mask
  input wire logic [DQ_W-1:0] dqOut,              // read data
  input wire logic [NUM_RCLK-1:0] readDataClock,  // read clocks
  input wire logic readValidFlag                  // read beat present
);
  localparam real HALF = 62.5;  // half link clock period in ns
  logic [DQ_W-1:0] rdQ[$];
  logic [17:0] pairOne;

  // pins idle, clocks still
  initial begin
    cmdClk = 1'b0;
    csN = 1'b1;
    weN = 1'b1;
    refN = 1'b1;
    bankAddr = 4'h0;
    addr = 20'h0;
    writeDataStrobe = 1'b0;
    dqIn = 36'h0;
    writeByteMask = 2'h0;
  end

  task automatic issue(input logic weV, input logic refV, input logic [BANK_W-1:0] b,
                       input logic [ADDR_W-1:0] a);
    #1.3;
    csN = 1'b0;
    weN = weV;
    refN = refV;
    bankAddr = b;
    addr = a;
    #(HALF);
    cmdClk = 1'b1;
    #(HALF);
    cmdClk = 1'b0;
    csN = 1'b1;
    weN = ~weV;
    refN = ~refV;
    bankAddr = ~b;
    addr = ~a;
  endtask

  task automatic write_beats(input int n, input logic [DQ_W-1:0] w[8],
                             input logic [MASK_W-1:0] m[8]);
    #1.3;
    for (int i = 0; i < n; i++) begin
      dqIn = w[i];
      writeByteMask = m[i];
      #30;
      writeDataStrobe = ~writeDataStrobe;
      #(HALF - 30);
    end
    dqIn = ~dqIn;
    writeByteMask = ~writeByteMask;
  endtask

  // pair 1 times bits 17:9, 35:27
  always @(readDataClock[1]) begin
    #29;
    pairOne = {dqOut[35:27], dqOut[17:9]};
  end

  always @(readDataClock[0]) begin
    #30;
    if (readValidFlag === 1'b1) begin
      rdQ.push_back({pairOne[17:9], dqOut[26:18], pairOne[8:0], dqOut[8:0]});
    end
  end
endmodule

// File: verif/ddrb_mem_if_tb.sv
// self-checking bench for the ddr burst memory interface
`timescale 1ns/10ps
module ddrb_mem_if_tb
  import ddrb_pkg::*;
();
  logic ref_clk, rst, cmdClk, csN, weN, refN, writeDataStrobe, dqOeN;
  logic readValidFlag, writeDropped;
  logic [BANK_W-1:0] bankAddr, accessBank, refreshBank;
  logic [ADDR_W-1:0] addr, accessAddr;
  logic [DQ_W-1:0] dqIn, dqOut;
  logic [MASK_W-1:0] writeByteMask;
  logic [NUM_RCLK-1:0] readDataClock;
  logic [BLEN_W-1:0] burstLen;
  logic [ROW_W-1:0] refreshRow;
  int fails = 0;
  int samples_checked = 0;
  int drops = 0;

  ddrb_mem_if uut (.ref_clk(ref_clk), .rst(rst), .cmdClk(cmdClk), .csN(csN), .weN(weN),
    .refN(refN), .bankAddr(bankAddr), .addr(addr), .writeDataStrobe(writeDataStrobe),
    .dqIn(dqIn), .writeByteMask(writeByteMask), .dqOut(dqOut), .dqOeN(dqOeN),
    .readDataClock(readDataClock), .readValidFlag(readValidFlag), .burstLen(burstLen),
    .accessBank(accessBank), .accessAddr(accessAddr), .refreshBank(refreshBank),
    .refreshRow(refreshRow), .writeDropped(writeDropped));

  ddrb_ctrl_model ctrl (.cmdClk(cmdClk), .csN(csN), .weN(weN), .refN(refN),
    .bankAddr(bankAddr), .addr(addr), .writeDataStrobe(writeDataStrobe), .dqIn(dqIn),
    .writeByteMask(writeByteMask), .dqOut(dqOut), .readDataClock(readDataClock),
    .readValidFlag(readValidFlag));

  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [DQ_W-1:0] seen,
                       input logic [DQ_W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  function automatic logic [DQ_W-1:0] word(input int i, input logic [7:0] base);
    return {4'(i), base, 24'hA5C3F1};
  endfunction

  function automatic logic [MASK_W-1:0] lane_mask(input int i);
    return (i == 1) ? 2'h1 : ((i == 2) ? 2'h2 : 2'h0);
  endfunction

  // masked lanes read back as zero
  function automatic logic [DQ_W-1:0] masked(input int i, input logic [7:0] base);
    logic [DQ_W-1:0] r;
    logic [MASK_W-1:0] m;
    r = word(i, base);
    m = lane_mask(i);
    if (m[0]) r[17:0] = 18'h0;
    if (m[1]) r[35:18] = 18'h0;
    return r;
  endfunction

  // count dropped write beats
  always @(posedge ref_clk) begin
    if (writeDropped === 1'b1) drops <= drops + 1;
  end

  // while a beat is out the device drives and all clock pairs agree
  always @(posedge ref_clk) begin
    if (rst === 1'b0 && readValidFlag === 1'b1) begin
      check("drive enable", DQ_W'(dqOeN), DQ_W'(0));
      check("clock pairs", DQ_W'(readDataClock), DQ_W'({NUM_RCLK{readDataClock[0]}}));
    end
  end

  task automatic set_len(input logic [1:0] code, input logic [BLEN_W-1:0] expLen);
    ctrl.issue(1'b0, 1'b0, 4'h0, {18'h0, code});
    @(posedge ref_clk);
    check("burst length", DQ_W'(burstLen), DQ_W'(expLen));
  endtask

  task automatic do_refresh(input logic [BANK_W-1:0] b, input logic [ROW_W-1:0] row);
    ctrl.issue(1'b1, 1'b0, b, 20'h0);
    @(posedge ref_clk);
    check("refresh bank", DQ_W'(refreshBank), DQ_W'(b));
    check("refresh row", DQ_W'(refreshRow), DQ_W'(row));
    check("access bank kept", DQ_W'(accessBank), DQ_W'(0));
  endtask

  task automatic do_write(input int len, input logic [BANK_W-1:0] b, input logic [7:0] base);
    logic [DQ_W-1:0] w[8];
    logic [MASK_W-1:0] m[8];
    for (int i = 0; i < 8; i++) begin
      w[i] = word(i, base);
      m[i] = lane_mask(i);
    end
    ctrl.issue(1'b0, 1'b1, b, {base, 12'hA53});
    @(posedge ref_clk);
    check("write bank", DQ_W'(accessBank), DQ_W'(b));
    check("write address", DQ_W'(accessAddr), DQ_W'({base, 12'hA53}));
    ctrl.write_beats(len, w, m);
    repeat (4) @(posedge ref_clk);
  endtask

  // mode 0 checks data, 1 checks zeros, 2 counts beats only
  task automatic do_read(input int len, input logic [BANK_W-1:0] b, input logic [7:0] base,
                         input int mode);
    int n;
    n = 0;
    ctrl.rdQ.delete();
    ctrl.issue(1'b1, 1'b1, b, {~base, 12'h3C5});
    @(posedge ref_clk);
    check("read bank", DQ_W'(accessBank), DQ_W'(b));
    check("read address", DQ_W'(accessAddr), DQ_W'({~base, 12'h3C5}));
    while (ctrl.rdQ.size() < len && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    while (readValidFlag !== 1'b0 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 400) begin
      fails++;
      complete_run();
    end
    check("read beats", DQ_W'(ctrl.rdQ.size()), DQ_W'(len));
    for (int i = 0; i < len && mode < 2; i++) begin
      check("read word", ctrl.rdQ[i], (mode == 1) ? 36'h0 : masked(i, base));
    end
    check("drive released", DQ_W'(dqOeN), DQ_W'(1));
    @(posedge ref_clk);
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    repeat (6) @(posedge ref_clk);
    check("reset length", DQ_W'(burstLen), DQ_W'(2));
    check("reset drive", DQ_W'(dqOeN), DQ_W'(1));
    check("reset valid", DQ_W'(readValidFlag), DQ_W'(0));
    check("reset row", DQ_W'(refreshRow), DQ_W'(0));
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    do_refresh(4'h5, 16'h0000);
    do_refresh(4'h5, 16'h0001);
    do_refresh(4'hF, 16'h0000);
    do_refresh(4'h5, 16'h0002);
    set_len(2'h0, 4'h2);
    set_len(2'h1, 4'h4);
    set_len(2'h2, 4'h8);
    set_len(2'h3, 4'h8);
    do_write(8, 4'hF, 8'h11);
    do_read(8, 4'hE, 8'h11, 0);
    set_len(2'h0, 4'h2);
    do_write(2, 4'h0, 8'h22);
    do_read(2, 4'h1, 8'h22, 0);
    set_len(2'h1, 4'h4);
    do_write(4, 4'h9, 8'h33);
    do_read(4, 4'h9, 8'h33, 0);
    set_len(2'h2, 4'h8);
    for (int k = 1; k < 5; k++) do_write(8, 4'(k), 8'(8'h40 + k));
    check("no drop while room", DQ_W'(drops), DQ_W'(0));
    do_write(8, 4'h5, 8'h50);
    check("drops at full", DQ_W'(drops), DQ_W'(7));
    for (int k = 1; k < 5; k++) do_read(8, 4'(k), 8'(8'h40 + k), 0);
    do_read(8, 4'h6, 8'h00, 2);
    do_read(8, 4'h7, 8'h00, 1);
    complete_run();
  end
endmodule
